// ### pciv_top.sv
// How it works
// [RULE1] 11-bit pointer, cleared to zero on reset
// [RULE2] 2K program space split into two 1K pages
// [RULE3] General group vectors to address 0x0001
// [RULE4] USB group vectors to address 0x000A
// [RULE5] Taken interrupt loads pointer with group vector
// [RULE6] Data lines run USB or PS/2 by firmware
// [RULE7] PS/2 mode: line state change raises interrupt
// [RULE8] Serial pin input only, feeds pattern detect
// [RULE9] 13-bit words, 112-byte SRAM, two endpoint FIFOs
// [RULE10] Page bit: 0 low page, 1 high page
// [RULE11] Five-level stack shared by calls and interrupts
// [RULE12] Both pending: general group first, one per entry
`timescale 1ns/1ps
module pciv_top
   import pciv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire pciv_seq_t seq,
   input wire logic page_select_bit,
   input wire logic irq_enable,
   input wire pciv_gen_irq_t gen_irq,
   input wire pciv_usb_irq_t usb_irq,
   input wire logic ps2_mode,
   input wire logic plus_line_in,
   input wire logic minus_line_in,
   input wire logic plus_line_port_bit,
   input wire logic minus_line_port_bit,
   input wire logic serial_input_pin,
   output logic [10:0] instruction_pointer,
   output logic [2:0] stack_level,
   output logic stack_overflow,
   output logic plus_line_out,
   output logic minus_line_out,
   output logic plus_line_oe,
   output logic minus_line_oe,
   output logic line_change_irq,
   output logic pattern_serial_in,
   output logic gen_taken,
   output logic usb_taken
);
   // ==========================================
   // Internal state
   logic [10:0] pc_ff;
   logic [10:0] stack_ff [PCIV_STACK_DEPTH];
   logic [2:0] sp_ff;
   logic ovf_ff;
   pciv_state_t state_ff;
   logic gen_taken_ff;
   logic usb_taken_ff;
   logic pout_ff;
   logic mout_ff;
   logic poe_ff;
   logic moe_ff;
   logic lchg_ff;
   logic ser_ff;
   logic line_change;

   function automatic logic [10:0] paged(input logic pg, input logic [10:0] a);
      paged = {pg, a[PCIV_PAGE_W-1:0]}; // [RULE2] [RULE10]
   endfunction

   pciv_line_mon u_mon
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ps2_mode(ps2_mode),
      .plus_line_in(plus_line_in),
      .minus_line_in(minus_line_in),
      .change_pulse(line_change)
   );

   // ==========================================
   // Interrupt arbitration
   wire logic gen_pend = irq_enable & ((|gen_irq) | line_change);
   wire logic usb_pend = irq_enable & (|usb_irq);
   // General group wins a tie; USB waits for the next entry
   wire logic take_gen = gen_pend; // [RULE12]
   wire logic take_usb = usb_pend & ~gen_pend; // [RULE12]
   wire logic take_any = take_gen | take_usb;
   wire logic [10:0] vector = take_gen ? PCIV_VEC_GEN : PCIV_VEC_USB; // [RULE3] [RULE4]
   wire logic push = take_any | (seq.call & ~take_any);
   wire logic pop = seq.ret & ~take_any & (sp_ff != 3'h0);
   // Pushing onto a full stack drops the oldest entry, as the small core does
   wire logic full = (sp_ff == PCIV_STACK_MAX);
   wire logic [10:0] ret_addr = take_any ? pc_ff : pc_ff + 11'h001;

   // ==========================================
   // Next pointer
   logic [10:0] nxt_pc;
   always_comb
   begin
      nxt_pc = pc_ff;
      if (take_any)
         nxt_pc = vector; // [RULE5]
      else if (seq.ret && sp_ff != 3'h0)
         nxt_pc = stack_ff[sp_ff - 3'h1];
      else if (seq.jump || seq.call)
         nxt_pc = paged(page_select_bit, seq.target); // [RULE10]
      else if (seq.step)
         nxt_pc = pc_ff + 11'h001;
   end

   wire pciv_state_t nxt_state = take_gen ? PCIV_ST_GEN : (take_usb ? PCIV_ST_USB : PCIV_ST_RUN);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_ff <= PCIV_PC_RESET; // [RULE1]
         state_ff <= PCIV_ST_RUN;
         gen_taken_ff <= 1'b0;
         usb_taken_ff <= 1'b0;
      end
      else
      begin
         pc_ff <= nxt_pc;
         state_ff <= nxt_state;
         gen_taken_ff <= take_gen;
         usb_taken_ff <= take_usb;
      end
   end

   // ==========================================
   // Return stack
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sp_ff <= 3'h0;
         ovf_ff <= 1'b0;
         for (int i = 0; i < PCIV_STACK_DEPTH; i++)
            stack_ff[i] <= PCIV_PC_RESET;
      end
      else if (push)
      begin
         if (full)
         begin
            for (int i = 0; i < PCIV_STACK_DEPTH - 1; i++)
               stack_ff[i] <= stack_ff[i+1];
            stack_ff[PCIV_STACK_DEPTH-1] <= ret_addr; // [RULE11]
            ovf_ff <= 1'b1;
         end
         else
         begin
            stack_ff[sp_ff] <= ret_addr; // [RULE11]
            sp_ff <= sp_ff + 3'h1;
         end
      end
      else if (pop)
         sp_ff <= sp_ff - 3'h1; // [RULE11]
   end

   // ==========================================
   // Data lines and serial pin
   wire logic nxt_poe = (ps2_mode == PCIV_MODE_PS2) & ~plus_line_port_bit; // [RULE6]
   wire logic nxt_moe = (ps2_mode == PCIV_MODE_PS2) & ~minus_line_port_bit; // [RULE6]

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pout_ff <= 1'b0;
         mout_ff <= 1'b0;
         poe_ff <= 1'b0;
         moe_ff <= 1'b0;
         lchg_ff <= 1'b0;
         ser_ff <= 1'b0;
      end
      else
      begin
         // Open-drain style: drive low only, release for a one
         pout_ff <= 1'b0;
         mout_ff <= 1'b0;
         poe_ff <= nxt_poe;
         moe_ff <= nxt_moe;
         lchg_ff <= line_change; // [RULE7]
         ser_ff <= serial_input_pin; // [RULE8]
      end
   end

   // 13-bit words, SRAM and endpoint FIFOs live outside; sizes are in the package [RULE9]
   assign instruction_pointer = pc_ff;
   assign stack_level = sp_ff;
   assign stack_overflow = ovf_ff;
   assign plus_line_out = pout_ff;
   assign minus_line_out = mout_ff;
   assign plus_line_oe = poe_ff;
   assign minus_line_oe = moe_ff;
   assign line_change_irq = lchg_ff;
   assign pattern_serial_in = ser_ff;
   assign gen_taken = gen_taken_ff;
   assign usb_taken = usb_taken_ff;
endmodule

// ### pciv_pkg.sv
package pciv_pkg;
   // ==========================================
   // Program space
   localparam int PCIV_PC_W = 11;
   localparam int PCIV_WORD_W = 13;
   localparam int PCIV_PAGE_W = 10;
   localparam logic [10:0] PCIV_PC_RESET = 11'h000;
   localparam logic [10:0] PCIV_VEC_GEN = 11'h001;
   localparam logic [10:0] PCIV_VEC_USB = 11'h00A;
   localparam logic PCIV_PAGE0 = 1'b0;
   localparam int PCIV_STACK_DEPTH = 5;
   localparam logic [2:0] PCIV_STACK_MAX = 3'h5;
   localparam int PCIV_SRAM_BYTES = 112;
   localparam int PCIV_EP0_BYTES = 8;
   localparam int PCIV_EP1_BYTES = 8;
   localparam logic PCIV_MODE_USB = 1'b0;
   localparam logic PCIV_MODE_PS2 = 1'b1;

   // ==========================================
   // Types
   typedef enum logic [1:0]
   {
      PCIV_ST_RUN = 2'b00,
      PCIV_ST_GEN = 2'b01,
      PCIV_ST_USB = 2'b11
   } pciv_state_t;

   typedef struct packed
   {
      logic timer_ovf;
      logic pat_high;
      logic pat_low;
      logic line_change;
   } pciv_gen_irq_t;

   typedef struct packed
   {
      logic ep0;
      logic suspend;
      logic bus_reset;
      logic resume;
   } pciv_usb_irq_t;

   typedef struct packed
   {
      logic step;
      logic jump;
      logic call;
      logic ret;
      logic [10:0] target;
   } pciv_seq_t;
endpackage

// ### pciv_line_mon.sv
`timescale 1ns/1ps
module pciv_line_mon
   import pciv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ps2_mode,
   input wire logic plus_line_in,
   input wire logic minus_line_in,
   output logic change_pulse
);
   logic [1:0] last_ff;
   logic armed_ff;
   logic change_ff;
   wire logic [1:0] now_lines = {minus_line_in, plus_line_in};
   // Arm one cycle after entering PS/2 so the mode switch itself is not an edge
   wire logic nxt_change = ps2_mode & armed_ff & (now_lines != last_ff); // [RULE7]

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_ff <= 2'h0;
         armed_ff <= 1'b0;
         change_ff <= 1'b0;
      end
      else
      begin
         last_ff <= now_lines;
         armed_ff <= ps2_mode;
         change_ff <= nxt_change;
      end
   end

   assign change_pulse = change_ff;
endmodule

// ### pciv_top_checker.sv
`timescale 1ns/1ps
module pciv_checker
   import pciv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire pciv_seq_t seq,
   input wire logic page_select_bit,
   input wire logic irq_enable,
   input wire pciv_gen_irq_t gen_irq,
   input wire pciv_usb_irq_t usb_irq,
   input wire logic ps2_mode,
   input wire logic serial_input_pin,
   input wire logic [10:0] instruction_pointer,
   input wire logic [2:0] stack_level,
   input wire logic stack_overflow,
   input wire logic line_change_irq,
   input wire logic pattern_serial_in,
   input wire logic gen_taken,
   input wire logic usb_taken
);
   // Nothing of higher priority competes
   wire logic plain = !irq_enable && !seq.ret && !seq.call;
   wire logic [10:0] ip = instruction_pointer;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_gen_vector: assert property (gen_taken |-> ip == PCIV_VEC_GEN)
      else $error("bad general vector");
   a_usb_vector: assert property (usb_taken |-> ip == PCIV_VEC_USB)
      else $error("bad usb vector");
   a_entry_enable: assert property (gen_taken || usb_taken |-> $past(irq_enable))
      else $error("entry not enabled");
   a_step_next: assert property
      (seq.step && !seq.jump && plain |=> ip == $past(ip) + 11'h1)
      else $error("bad step");
   a_jump_page: assert property
      (seq.jump && plain |=> ip == {$past(page_select_bit), $past(seq.target[9:0])})
      else $error("bad jump page");
   a_stack_max: assert property (stack_level <= PCIV_STACK_MAX)
      else $error("stack too deep");
   a_serial_copy: assert property
      ($past(rst_n) |-> pattern_serial_in == $past(serial_input_pin))
      else $error("bad serial copy");
   a_ps2_only: assert property (!ps2_mode ##1 !ps2_mode |=> !line_change_irq)
      else $error("line irq in usb mode");
   a_reset_clear: assert property
      ($rose(rst_n) |-> ip == PCIV_PC_RESET && stack_level == 3'h0)
      else $error("pointer not cleared by reset");
   a_call_push: assert property
      (seq.call && !seq.ret && !irq_enable && stack_level != PCIV_STACK_MAX
       |=> stack_level == $past(stack_level) + 3'h1)
      else $error("call did not push");
   a_ret_pop: assert property
      (seq.ret && !seq.call && !irq_enable && stack_level != 3'h0
       |=> stack_level == $past(stack_level) - 3'h1)
      else $error("return did not pop");
   a_full_overflow: assert property
      (seq.call && stack_level == PCIV_STACK_MAX |=> stack_overflow)
      else $error("overflow not flagged");
   a_gen_first: assert property
      (irq_enable && (|gen_irq) |=> gen_taken && !usb_taken)
      else $error("general group not served first");
endmodule
bind pciv_top pciv_checker pciv_checker_inst (.*);

// ### pciv_ps2_host.sv
`timescale 1ns/1ps
module pciv_ps2_host
(
   input wire logic plus_line_oe,
   input wire logic minus_line_oe,
   input wire logic host_plus_low,
   input wire logic host_minus_low,
   output logic plus_line_in,
   output logic minus_line_in
);
   // Pulled up; whoever pulls low wins
   assign plus_line_in = !(plus_line_oe || host_plus_low);
   assign minus_line_in = !(minus_line_oe || host_minus_low);
endmodule

// ### program_counter_interrupt_vectoring_tb.sv
`timescale 1ns/1ps
module program_counter_interrupt_vectoring_tb
   import pciv_pkg::*;
   ;
   logic sys_clk = 0, rst_n = 0, page_select_bit = 0, irq_enable = 0, ps2_mode = 0;
   logic plus_line_port_bit = 1, minus_line_port_bit = 1, serial_input_pin = 0;
   logic plus_line_in, minus_line_in, plus_line_out, minus_line_out, plus_line_oe;
   logic minus_line_oe, line_change_irq, pattern_serial_in, gen_taken, usb_taken;
   logic stack_overflow, host_plus_low = 0, host_minus_low = 0;
   logic [10:0] instruction_pointer;
   logic [2:0] stack_level;
   pciv_seq_t seq = '0;
   pciv_gen_irq_t gen_irq = '0;
   pciv_usb_irq_t usb_irq = '0;
   wire logic [10:0] ip = instruction_pointer;
   int fails = 0;
   int n_compared = 0;
   localparam logic [15:0] PG1 = 16'h8000, STP = 16'h4000, JMP = 16'h2000;
   localparam logic [15:0] CAL = 16'h1000, RTN = 16'h0800;
   always #10 sys_clk = ~sys_clk;
   pciv_top pciv_top_inst (.*);
   pciv_ps2_host pciv_ps2_host_inst (.*);
   // ==========================================
   // Helpers
   task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task complete_run;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Held one cycle only: a held level would be re-taken
   task op(input logic [15:0] s, input logic [7:0] q);
      @(posedge sys_clk);
      {page_select_bit, seq} <= s;
      serial_input_pin <= ^s;
      {gen_irq, usb_irq} <= q;
      irq_enable <= |q;
      @(posedge sys_clk);
      {seq, gen_irq, usb_irq, irq_enable} <= 24'h0;
      #1;
   endtask
   task wait_lci(input logic e);
      logic seen;
      seen = 0;
      repeat (6) @(negedge sys_clk) seen |= line_change_irq;
      chk("line_change_irq", {10'h0, e}, {10'h0, seen});
      if (e && !seen)
         complete_run();
   endtask
   // ==========================================
   // Scenarios
   task t_jump;
      op(PG1 | JMP | 16'h3FF, 8'h0);
      chk("ptr", 11'h7FF, ip);
      op(STP, 8'h0);
      chk("ptr", 11'h000, ip);
      chk("serial", 11'h1, {10'h0, pattern_serial_in});
      op(JMP | 16'h3FF, 8'h0);
      chk("ptr", 11'h3FF, ip);
   endtask
   task t_call;
      op(PG1 | CAL | 16'h5, 8'h0);
      chk("ptr", 11'h405, ip);
      op(RTN, 8'h0);
      chk("ptr", 11'h400, ip);
   endtask
   task t_irq;
      for (int i = 0; i < 8; i++)
      begin
         op(16'h0, 8'h80 >> i);
         chk("vector", i < 4 ? PCIV_VEC_GEN : PCIV_VEC_USB, ip);
         chk("taken", 11'h1, {10'h0, i < 4 ? gen_taken : usb_taken});
         op(RTN, 8'h0);
         chk("return", 11'h400, ip);
      end
   endtask
   task t_both;
      op(16'h0, 8'h88);
      chk("ptr", PCIV_VEC_GEN, ip);
      chk("usb_taken", 11'h0, {10'h0, usb_taken});
      op(16'h0, 8'h08);
      chk("ptr", PCIV_VEC_USB, ip);
      chk("depth", 11'h2, {8'h0, stack_level});
      op(RTN, 8'h0);
      chk("ptr", PCIV_VEC_GEN, ip);
      op(RTN, 8'h0);
   endtask
   task t_lines;
      @(posedge sys_clk);
      ps2_mode <= 1;
      @(posedge sys_clk);
      host_plus_low <= 1;
      wait_lci(1);
      chk("plus_oe", 11'h0, {10'h0, plus_line_oe});
      @(posedge sys_clk);
      minus_line_port_bit <= 0;
      wait_lci(1);
      chk("oe", 11'h1, {10'h0, minus_line_oe});
      chk("minus_out", 11'h0, {10'h0, minus_line_out});
      chk("plus_out", 11'h0, {10'h0, plus_line_out});
      @(posedge sys_clk);
      ps2_mode <= 0;
      repeat (4) @(posedge sys_clk);
      host_plus_low <= 0;
      host_minus_low <= 1;
      wait_lci(0);
      chk("oe", 11'h0, {10'h0, minus_line_oe});
   endtask
   task t_over;
      repeat (6) op(PG1 | CAL | 16'h5, 8'h0);
      chk("depth", 11'h5, {8'h0, stack_level});
      chk("overflow", 11'h1, {10'h0, stack_overflow});
   endtask
   // Reset in mid-run must clear a pointer that is far from zero
   task t_reset;
      @(posedge sys_clk);
      rst_n <= 0;
      @(negedge sys_clk);
      chk("ptr", 11'h000, ip);
      chk("depth", 11'h0, {8'h0, stack_level});
      chk("overflow", 11'h0, {10'h0, stack_overflow});
      repeat (2) @(posedge sys_clk);
      rst_n <= 1;
      op(STP, 8'h0);
      chk("ptr", 11'h001, ip);
   endtask
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1;
      @(negedge sys_clk);
      chk("ptr", 11'h000, ip);
      t_jump();
      t_call();
      t_irq();
      t_both();
      t_lines();
      t_over();
      t_reset();
      complete_run();
   end
endmodule
